// *** rtl/cvp_component_video.sv ***
// Component video datapath: matrix, downformatter with peaking, adjustment, output FIFO
//
// Function
// - Matrix takes 9-bit RGB, yields 9-bit Y, Cb, Cr at unity gain.
// - Luma is 0.299 R plus 0.587 G plus 0.114 B.
// - Cb is 0.5772 of (B minus Y), Cr is 0.7296 of (R minus Y).
// - Component input bypasses the matrix with the same latency.
// - Both colour differences are low-pass filtered before decimation.
// - Cr is delayed one sample so both chroma samples pair with slot's first luma.
// - Phase 0 marks slot's first clock carrying Cb; phase 1 carries Cr.
// - Multiplexed chroma is registered after the multiplexer.
// - Luma high-pass peaking from delay registers, about 2 dB at 6.75 MHz.
// - Peaking has unity DC gain and saturates to 0 through 511.
// - One control bit at subaddress 29H enables the whole peaking filter.
// - Adjustment scales colour differences by an 8-bit saturation setting.
// - Adjustment applies 8-bit contrast gain and 8-bit brightness offset to luma.
// - All adjusted outputs are clamped to 1 through 254.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module cvp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rd_q];
	assign level_o = cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module cvp_component_video #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pix_valid_i,
	input wire cvp_pkg::cvp_pix_t pix_i,
	output logic pix_ready_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output cvp_pkg::cvp_out_t out_o
);
	localparam int OW = $bits(cvp_pkg::cvp_out_t);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic comp_in;
		logic luma_peaking_enable;
		logic [7:0] comp_saturation_gain;
		logic [7:0] comp_contrast_gain;
		logic [7:0] comp_brightness_offset;
		logic rdy;
		logic [15:0] pix_cnt;
		logic s1_v;
		logic [8:0] s1_y;
		logic [8:0] s1_cb;
		logic [8:0] s1_cr;
		logic [8:0] cb_h1;
		logic [8:0] cb_h2;
		logic [8:0] cr_h1;
		logic [8:0] cr_h2;
		logic [8:0] y_h1;
		logic [8:0] y_h2;
		logic s2_v;
		logic [8:0] s2_y;
		logic [8:0] s2_cb;
		logic [8:0] s2_cr;
		logic phase;
		logic [8:0] cr_hold;
		logic s3_v;
		logic [8:0] s3_y;
		logic [8:0] s3_c;
		logic s3_ph;
		logic s4_v;
		cvp_pkg::cvp_out_t s4;
	} cvp_state_t;

	cvp_state_t q;
	cvp_state_t d;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic [OW-1:0] fifo_out;

	// Saturate to the 9-bit sample range
	function automatic logic [8:0] cvp_sat9(input int v);
		if (v < cvp_pkg::CVP_MIN9) begin
			return 9'(cvp_pkg::CVP_MIN9);
		end else if (v > cvp_pkg::CVP_MAX9) begin
			return 9'(cvp_pkg::CVP_MAX9);
		end
		return 9'(v);
	endfunction

	// Clamp to the legal 8-bit video range, keeping 0 and 255 for timing codes
	function automatic logic [7:0] cvp_lim8(input int v);
		if (v < cvp_pkg::CVP_LIM_MIN) begin
			return 8'(cvp_pkg::CVP_LIM_MIN);
		end else if (v > cvp_pkg::CVP_LIM_MAX) begin
			return 8'(cvp_pkg::CVP_LIM_MAX);
		end
		return 8'(v);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		int r;
		int g;
		int b;
		int y;
		int hp;
		int pk;
		int yl;
		int cv;
		logic acc;
		r = 0;
		g = 0;
		b = 0;
		y = 0;
		hp = 0;
		pk = 0;
		yl = 0;
		cv = 0;
		acc = 1'b0;
		d = q;

		// Wishbone slave: answer one cycle after the strobe, drop ack the cycle after
		acc = wb_cyc_i && wb_stb_i && !q.ack;
		d.ack = acc;
		if (acc) begin
			unique case (wb_adr_i)
				cvp_pkg::CVP_ADR_MODE: d.rdat = 32'(q.comp_in);
				cvp_pkg::CVP_ADR_PEAK: d.rdat = 32'(q.luma_peaking_enable);
				cvp_pkg::CVP_ADR_SAT: d.rdat = 32'(q.comp_saturation_gain);
				cvp_pkg::CVP_ADR_CON: d.rdat = 32'(q.comp_contrast_gain);
				cvp_pkg::CVP_ADR_BRI: d.rdat = 32'(q.comp_brightness_offset);
				cvp_pkg::CVP_ADR_STAT: d.rdat = {12'h000, 4'(fifo_level), q.pix_cnt};
				default: d.rdat = 32'h0000_0000;
			endcase
		end
		// Writes land at the edge where the master sees ack
		if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				cvp_pkg::CVP_ADR_MODE: d.comp_in = wb_dat_i[cvp_pkg::CVP_BIT_COMP_IN];
				cvp_pkg::CVP_ADR_PEAK: begin
					d.luma_peaking_enable = wb_dat_i[cvp_pkg::CVP_BIT_PEAK_EN];
				end
				cvp_pkg::CVP_ADR_SAT: d.comp_saturation_gain = wb_dat_i[7:0];
				cvp_pkg::CVP_ADR_CON: d.comp_contrast_gain = wb_dat_i[7:0];
				cvp_pkg::CVP_ADR_BRI: d.comp_brightness_offset = wb_dat_i[7:0];
				default: d.rdy = q.rdy;
			endcase
		end

		// Input throttle leaves room for every sample still in the pipeline
		d.rdy = (int'(fifo_level) < FIFO_DEPTH - cvp_pkg::CVP_FIFO_SLACK);

		// Stage 1: matrix or matched bypass, both one register deep
		d.s1_v = pix_valid_i && q.rdy;
		if (d.s1_v) begin
			d.pix_cnt = q.pix_cnt + 16'h0001;
			r = int'(pix_i.r);
			g = int'(pix_i.g);
			b = int'(pix_i.b);
			if (q.comp_in) begin
				d.s1_y = pix_i.r;
				d.s1_cb = pix_i.g;
				d.s1_cr = pix_i.b;
			end else begin
				y = (cvp_pkg::CVP_K_YR * r + cvp_pkg::CVP_K_YG * g + cvp_pkg::CVP_K_YB * b
					+ cvp_pkg::CVP_MAT_HALF) >>> cvp_pkg::CVP_MAT_SHIFT;
				d.s1_y = cvp_sat9(y);
				d.s1_cb = cvp_sat9(((cvp_pkg::CVP_K_CB * (b - y) + cvp_pkg::CVP_MAT_HALF)
					>>> cvp_pkg::CVP_MAT_SHIFT) + cvp_pkg::CVP_C9_MID);
				d.s1_cr = cvp_sat9(((cvp_pkg::CVP_K_CR * (r - y) + cvp_pkg::CVP_MAT_HALF)
					>>> cvp_pkg::CVP_MAT_SHIFT) + cvp_pkg::CVP_C9_MID);
			end
		end

		// Stage 2: chroma anti-alias [1 2 1]/4, luma delay line doubles as peaking taps
		d.s2_v = q.s1_v;
		if (q.s1_v) begin
			d.cb_h1 = q.s1_cb;
			d.cb_h2 = q.cb_h1;
			d.cr_h1 = q.s1_cr;
			d.cr_h2 = q.cr_h1;
			d.y_h1 = q.s1_y;
			d.y_h2 = q.y_h1;
			d.s2_cb = 9'((int'(q.s1_cb) + 2 * int'(q.cb_h1) + int'(q.cb_h2)
				+ cvp_pkg::CVP_LPF_HALF) >>> cvp_pkg::CVP_LPF_SHIFT);
			d.s2_cr = 9'((int'(q.s1_cr) + 2 * int'(q.cr_h1) + int'(q.cr_h2)
				+ cvp_pkg::CVP_LPF_HALF) >>> cvp_pkg::CVP_LPF_SHIFT);
			hp = 2 * int'(q.y_h1) - int'(q.s1_y) - int'(q.y_h2);
			pk = int'(q.y_h1) + (hp >>> cvp_pkg::CVP_PEAK_SHIFT);
			// Filtered or plain tap share the same delay, so switching is glitch-free
			d.s2_y = q.luma_peaking_enable ? cvp_sat9(pk) : q.y_h1;
		end

		// Stage 3: 4:2:2 multiplexer, result held in a register
		d.s3_v = q.s2_v;
		if (q.s2_v) begin
			d.phase = ~q.phase;
			d.s3_y = q.s2_y;
			d.s3_ph = q.phase;
			if (!q.phase) begin
				d.s3_c = q.s2_cb;
				d.cr_hold = q.s2_cr;
			end else begin
				d.s3_c = q.cr_hold;
			end
		end

		// Stage 4: contrast, brightness, saturation and legal-range limiting
		d.s4_v = q.s3_v;
		if (q.s3_v) begin
			yl = ((int'(q.s3_y) >>> 1) * int'(q.comp_contrast_gain) + cvp_pkg::CVP_GAIN_HALF)
				>>> cvp_pkg::CVP_GAIN_SHIFT;
			yl = yl + int'(q.comp_brightness_offset) - cvp_pkg::CVP_C8_MID;
			cv = (((int'(q.s3_c) >>> 1) - cvp_pkg::CVP_C8_MID) * int'(q.comp_saturation_gain)
				+ cvp_pkg::CVP_GAIN_HALF) >>> cvp_pkg::CVP_GAIN_SHIFT;
			d.s4.luma = cvp_lim8(yl);
			d.s4.chroma = cvp_lim8(cv + cvp_pkg::CVP_C8_MID);
			d.s4.cb_phase_n = q.s3_ph;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.comp_in <= cvp_pkg::CVP_RST_COMP;
			q.luma_peaking_enable <= cvp_pkg::CVP_RST_PEAK;
			q.comp_saturation_gain <= cvp_pkg::CVP_RST_SAT;
			q.comp_contrast_gain <= cvp_pkg::CVP_RST_CON;
			q.comp_brightness_offset <= cvp_pkg::CVP_RST_BRI;
		end else begin
			q <= d;
		end
	end

	// Output buffer; a stalled sink throttles the input through pix_ready_o
	cvp_fifo #(
		.WIDTH(OW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(q.s4_v),
		// The throttle stops input once the level reaches DEPTH-6, so the FIFO is never full on a push
		.in_ready_o(),
		.in_data_i(q.s4),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(fifo_out),
		.level_o(fifo_level)
	);

	assign out_o = cvp_pkg::cvp_out_t'(fifo_out);
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign pix_ready_o = q.rdy;
endmodule

// *** rtl/cvp_pkg.sv ***
// Package for the component video processing datapath: map, coefficients, limits, types
package cvp_pkg;
	// Register byte addresses (index times four for the printed subaddress)
	localparam logic [7:0] CVP_IDX_PEAK = 8'h29;
	localparam logic [7:0] CVP_ADR_PEAK = 8'ha4;
	localparam logic [7:0] CVP_ADR_MODE = 8'h00;
	localparam logic [7:0] CVP_ADR_SAT = 8'h04;
	localparam logic [7:0] CVP_ADR_CON = 8'h08;
	localparam logic [7:0] CVP_ADR_BRI = 8'h0c;
	localparam logic [7:0] CVP_ADR_STAT = 8'h10;
	// Field positions
	localparam int CVP_BIT_PEAK_EN = 0;
	localparam int CVP_BIT_COMP_IN = 0;
	// Reset values
	localparam logic [7:0] CVP_RST_SAT = 8'h40;
	localparam logic [7:0] CVP_RST_CON = 8'h40;
	localparam logic [7:0] CVP_RST_BRI = 8'h80;
	localparam logic CVP_RST_PEAK = 1'b0;
	localparam logic CVP_RST_COMP = 1'b0;
	// Matrix coefficients, scaled by 2^CVP_MAT_SHIFT
	localparam int CVP_MAT_SHIFT = 8;
	localparam int CVP_MAT_HALF = 128;
	localparam int CVP_K_YR = 77;
	localparam int CVP_K_YG = 150;
	localparam int CVP_K_YB = 29;
	localparam int CVP_K_CB = 148;
	localparam int CVP_K_CR = 187;
	localparam int CVP_C9_MID = 256;
	localparam int CVP_MAX9 = 511;
	localparam int CVP_MIN9 = 0;
	// Peaking: high-pass term scaled down by 2^4 gives 1.25 at half pixel rate
	localparam int CVP_PEAK_SHIFT = 4;
	localparam int CVP_LPF_SHIFT = 2;
	localparam int CVP_LPF_HALF = 2;
	// Adjustment stage: gain 64 is unity, brightness 128 is no offset
	localparam int CVP_GAIN_SHIFT = 6;
	localparam int CVP_GAIN_HALF = 32;
	localparam int CVP_C8_MID = 128;
	localparam int CVP_LIM_MIN = 1;
	localparam int CVP_LIM_MAX = 254;
	localparam int CVP_FIFO_SLACK = 6;

	typedef struct packed {
		logic [8:0] r;
		logic [8:0] g;
		logic [8:0] b;
	} cvp_pix_t;

	typedef struct packed {
		logic cb_phase_n;
		logic [7:0] luma;
		logic [7:0] chroma;
	} cvp_out_t;
endpackage

// *** tb/cvp_adc_src.sv ***
// Stand-in for the converters feeding samples to the datapath
`timescale 1ns/1ps
module cvp_adc_src (
	input wire logic clk_i,
	input wire logic ready_i,
	output logic valid_o,
	output cvp_pkg::cvp_pix_t pix_o
);
	initial begin
		valid_o = 1'b0;
		pix_o = '0;
	end
	// Idle cycles scramble the bus so no stale sample looks valid
	task automatic idle(input int n);
		repeat (n) begin
			valid_o <= 1'b0;
			pix_o <= ~pix_o;
			@(posedge clk_i);
		end
	endtask
	// Valid stays up between samples only when gap is 0, giving back-to-back transfers
	task automatic send(input cvp_pkg::cvp_pix_t p, input int gap);
		idle(gap);
		valid_o <= 1'b1;
		pix_o <= p;
		do @(posedge clk_i); while (ready_i !== 1'b1);
	endtask
endmodule

// *** tb/cvp_component_video_bench.sv ***
// Self-checking bench for the component video datapath
`timescale 1ns/1ps
module cvp_component_video_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ordy = 1'b0, stall = 1'b0, comp = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, pvalid, prdy, ovalid;
	cvp_pkg::cvp_pix_t pix;
	cvp_pkg::cvp_out_t odat;
	logic [17:0] oq[$];
	logic [31:0] rq[$];
	int err_total = 0, check_count = 0, phase = 0, sat = 64, con = 64, bri = 128;
	logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'ha4, 8'h10, 8'h14};
	logic [7:0] rv[7] = '{8'h00, 8'h40, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
	cvp_pkg::cvp_pix_t cols[4] = '{27'h7ffffff, 27'h0, 27'h7fc0000, 27'h1ff};
	cvp_component_video #(.FIFO_DEPTH(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pix_valid_i(pvalid),
		.pix_i(pix), .pix_ready_o(prdy), .out_valid_o(ovalid), .out_ready_i(ordy),
		.out_o(odat));
	cvp_adc_src src (.clk_i(clk_i), .ready_i(prdy), .valid_o(pvalid), .pix_o(pix));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) ordy <= !stall && ($urandom % 4 != 0);
	//////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		cmp(oq.size(), 0);
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic int lim(input int v, input int lo, input int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	function automatic logic [16:0] expw(input cvp_pkg::cvp_pix_t p, input logic ph);
		int r, g, b, y, c;
		r = p.r;
		g = p.g;
		b = p.b;
		y = comp ? r : (77 * r + 150 * g + 29 * b + 128) >>> 8;
		if (ph) c = comp ? b : lim(((187 * (r - y) + 128) >>> 8) + 256, 0, 511);
		else c = comp ? g : lim(((148 * (b - y) + 128) >>> 8) + 256, 0, 511);
		y = lim((((y / 2) * con + 32) >>> 6) + bri - 128, 1, 254);
		c = lim((((c / 2 - 128) * sat + 32) >>> 6) + 128, 1, 254);
		return {ph, y[7:0], c[7:0]};
	endfunction
	//////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic cfg(input logic [31:0] r);
		comp = r[0];
		sat = r[15:8];
		con = r[23:16];
		bri = r[31:24];
		wb(1'b1, 8'h00, {31'h0, r[0]});
		wb(1'b1, 8'h04, sat);
		wb(1'b1, 8'h08, con);
		wb(1'b1, 8'h0c, bri);
		wb(1'b1, 8'ha4, {31'h0, r[1]});
		rd(8'ha4, {31'h0, r[1]});
	endtask
	// Filter taps need a few equal samples, so early words check phase only
	task automatic run(input cvp_pkg::cvp_pix_t p, input int n);
		for (int i = 0; i < n; i++) begin
			oq.push_back({i > 4, expw(p, phase[0])});
			phase++;
			src.send(p, $urandom % 3);
		end
		src.idle(1);
		for (int k = 0; k < 600 && oq.size() > 0; k++) @(posedge clk_i);
	endtask
	//////////////////////////////
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) cmp(rdat, rq.size() ? rq.pop_front() : 32'hffffffff);
	end
	always @(posedge clk_i) begin
		logic [17:0] n;
		logic [16:0] m;
		if (ovalid === 1'b1 && ordy === 1'b1) begin
			n = oq.size() ? oq.pop_front() : 18'h3ffff;
			m = n[17] ? 17'h1ffff : 17'h10000;
			cmp({15'h0, odat & m}, {15'h0, n[16:0] & m});
		end
	end
	initial begin
		#500000;
		err_total++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h0f02));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i]) rd(ra[i], {24'h0, rv[i]});
		wb(1'b1, 8'h14, 32'hff);
		rd(8'h14, 32'h0);
		foreach (cols[i]) run(cols[i], 8);
		for (int k = 0; k < 8; k++) begin
			cfg(k == 0 ? 32'h00ff0003 : $urandom);
			run(27'($urandom), 8);
		end
		stall <= 1'b1;
		fork
			run(27'h1234567, 12);
			begin
				repeat (40) @(posedge clk_i);
				cmp({prdy, ovalid}, 2'b01);
				stall <= 1'b0;
			end
		join
		rd(8'h10, {16'h0, phase[15:0]});
		end_sim();
	end
endmodule

// *** tb/cvp_component_video_chk.sv ***
// Port checker for the component video datapath
`timescale 1ns/1ps
module cvp_component_video_chk #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic pix_valid_i,
	input wire logic pix_ready_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i,
	input wire cvp_pkg::cvp_out_t out_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic last_q;
	logic last_d;
	// Reset to Cr so the first popped word must be Cb
	always_comb begin
		last_d = last_q;
		if (out_valid_o && out_ready_i) last_d = out_o.cb_phase_n;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) last_q <= 1'b1;
		else last_q <= last_d;
	end
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack wider than one cycle");
	AST_ACK_DUE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	AST_Y_LIM: assert property (out_valid_o |-> out_o.luma inside {[8'h01:8'hfe]})
		else $error("luma outside limits");
	AST_C_LIM: assert property (out_valid_o |-> out_o.chroma inside {[8'h01:8'hfe]})
		else $error("chroma outside limits");
	AST_PHASE: assert property (out_valid_o && out_ready_i |-> out_o.cb_phase_n != last_q)
		else $error("chroma phase did not alternate");
	AST_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
		else $error("output word changed while stalled");
	AST_LAT: assert property (pix_valid_i && pix_ready_o |-> ##[1:5] out_valid_o)
		else $error("output late");
endmodule
bind cvp_component_video cvp_component_video_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o),
	.out_ready_i(out_ready_i), .out_o(out_o));
